//--- design/relay_status.sv
/*
  relay status block: self-diagnostics, front lamps, last-trip display,
  measurement scroll/freeze, bus framing settings and operation counters,
  all but the front lamps reached over an AXI4-Lite slave.
  assumes keys are debounced one-cycle pulses, trip inputs are pulses,
  and all inputs are synchronous to mclk.
*/
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module relay_status #(
  parameter int FLASH_CYC = relay_pkg::FLASH_CYC,
  parameter int SCROLL_CYC = relay_pkg::SCROLL_CYC,
  parameter int DIAG_CYC = relay_pkg::DIAG_CYC,
  parameter int TEST_CYC = relay_pkg::TEST_CYC,
  parameter int BAUD_SLOW_CYC = relay_pkg::BAUD_SLOW_CYC,
  parameter int BAUD_FAST_CYC = relay_pkg::BAUD_FAST_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic adc_ok,
  input wire logic dsp_ok,
  input wire logic [7:0] nv_sum,
  input wire logic [8:0] nv_cfg_in,
  output logic [8:0] nv_cfg_out,
  output logic nv_write,
  input wire logic breaker_position_input,
  input wire logic bf_active,
  input wire logic bf_event,
  input wire logic [6:0] timing_vec,
  input wire logic [6:0] trip_vec,
  input wire logic ext_trip,
  input wire logic [3:0] reclose_evt,
  input wire logic reclose_fail,
  input wire logic hw_recovery,
  input wire logic reset_key,
  input wire logic up_key,
  input wire logic down_key,
  input wire logic [relay_pkg::NUM_MEAS-1:0][15:0] meas_in,
  output logic irf_trip_out,
  output logic irf_event,
  output logic lamp_open,
  output logic lamp_closed,
  output logic lamp_trip,
  output logic power_fault_lamp,
  output logic last_trip_caption,
  output logic [3:0] cause_code,
  output logic cause_blink,
  output logic [2:0] disp_index,
  output logic [15:0] disp_value,
  output logic [4:0] node_address,
  output logic [1:0] parity_mode,
  output logic baud_fast,
  output logic proto_iec,
  output logic bit_tick,
  input wire logic [7:0] rx_addr,
  input wire logic rx_addr_valid,
  output logic frame_accept
);
  typedef struct packed {
    logic aw_got, w_got, bvalid, rd_pend, rvalid;
    logic [1:0] bresp, rresp;
    logic [7:0] awaddr, raddr;
    logic [31:0] wdata, rdata;
    logic [1:0] wstrb;
    logic [1:0] ctrl;
    logic [8:0] cfg, act_cfg;
    logic cfg_loaded, chk_pend, nv_wr;
    relay_pkg::state_t st;
    logic [27:0] test_cnt, flash_cnt, scroll_cnt, diag_cnt;
    logic [13:0] baud_cnt;
    logic test_bad, irf, irf_evt, blink, bit_tick;
    logic trip_latch, show_last, paused, freeze_q, frame_accept;
    logic [3:0] cause;
    logic [2:0] idx;
    logic [relay_pkg::NUM_MEAS-1:0][15:0] snap;
    logic [15:0] disp_val;
    logic lamp_open, lamp_closed, lamp_trip, lamp_pwr, irf_out;
  } state_t;
  state_t s_reg, s_next;
  logic [15:0] cnt_rdata;
  logic [relay_pkg::NUM_CNT-1:0] cnt_inc;
  logic [7:0] cnt_byte;
  logic [7:0] csum;
  logic diag_tick, scroll_tick, fault, any_trip, wr_ok;

  counter_mem u_counters (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .inc(cnt_inc),
    .raddr(cnt_byte[5:2]),
    .rdata(cnt_rdata)
  );

  // counter slots: 7 delayed trips, failure, fault, 4 reclosures, failed, recovery
  assign cnt_inc = {hw_recovery, reclose_fail, reclose_evt, s_reg.irf_evt,
                    bf_event, trip_vec};
  assign cnt_byte = s_axi_araddr - relay_pkg::CNT_OFS;
  assign csum = s_reg.cfg[7:0] + {7'h00, s_reg.cfg[8]} + {6'h00, s_reg.ctrl};
  assign diag_tick = s_reg.diag_cnt == 28'(DIAG_CYC - 1);
  assign scroll_tick = s_reg.scroll_cnt == 28'(SCROLL_CYC - 1);
  // checks fail on a bad converter, processor or stored-settings sum
  assign fault = (s_reg.st == relay_pkg::ST_RUN) &&
                 ((diag_tick && (!adc_ok || !dsp_ok)) ||
                  (s_reg.chk_pend && csum != nv_sum));
  assign any_trip = (|trip_vec) || ext_trip ||
                    (s_reg.irf_evt && s_reg.ctrl[relay_pkg::CTRL_IRF_TRIP]);
  assign wr_ok = s_reg.awaddr == relay_pkg::CTRL_OFS || s_reg.awaddr == relay_pkg::CFG_OFS;

  always_comb begin
    s_next = s_reg;
    s_next.nv_wr = 1'b0;
    s_next.irf_evt = 1'b0;
    s_next.bit_tick = 1'b0;
    s_next.frame_accept = 1'b0;
    s_next.chk_pend = 1'b0;
    // bus slave: address and data are taken in either order
    if (s_axi_awvalid && !s_reg.aw_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_reg.w_got && !s_reg.bvalid) begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb[1:0];
    end
    if (s_reg.aw_got && s_reg.w_got) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = wr_ok ? relay_pkg::RESP_OK : relay_pkg::RESP_SLVERR;
      if (s_reg.awaddr == relay_pkg::CTRL_OFS && s_reg.wstrb[0]) begin
        s_next.ctrl = s_reg.wdata[1:0];
        s_next.chk_pend = 1'b1;
      end
      // framing is stored only; the active copy waits for the next power-up
      if (s_reg.awaddr == relay_pkg::CFG_OFS && s_reg.wstrb != 2'h0) begin
        if (s_reg.wstrb[0]) begin
          s_next.cfg[7:0] = s_reg.wdata[7:0];
        end
        if (s_reg.wstrb[1]) begin
          s_next.cfg[8] = s_reg.wdata[8];
        end
        s_next.nv_wr = 1'b1;
        s_next.chk_pend = 1'b1;
      end
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    // read: counter memory answers one edge after the address is taken
    if (s_axi_arvalid && !s_reg.rd_pend && !s_reg.rvalid) begin
      s_next.rd_pend = 1'b1;
      s_next.raddr = s_axi_araddr;
    end
    if (s_reg.rd_pend) begin
      s_next.rd_pend = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rresp = relay_pkg::RESP_OK;
      s_next.rdata = 32'h0000_0000;
      if (s_reg.raddr == relay_pkg::CTRL_OFS) begin
        s_next.rdata[1:0] = s_reg.ctrl;
      end else if (s_reg.raddr == relay_pkg::CFG_OFS) begin
        s_next.rdata[8:0] = s_reg.cfg;
      end else if (s_reg.raddr == relay_pkg::STATUS_OFS) begin
        s_next.rdata[5:0] = {s_reg.paused, s_reg.show_last, s_reg.trip_latch,
                             s_reg.irf, s_reg.st == relay_pkg::ST_RUN, s_reg.chk_pend};
        s_next.rdata[11:8] = s_reg.cause;
      end else if (s_reg.raddr == relay_pkg::ACT_CFG_OFS) begin
        s_next.rdata[8:0] = s_reg.act_cfg;
      end else if (s_reg.raddr == relay_pkg::DISP_OFS) begin
        s_next.rdata[18:0] = {s_reg.idx, s_reg.disp_val};
      end else if (s_reg.raddr >= relay_pkg::CNT_OFS && s_reg.raddr[1:0] == 2'h0 &&
                   s_reg.raddr < relay_pkg::CNT_OFS + 8'(4 * relay_pkg::NUM_CNT)) begin
        s_next.rdata[15:0] = cnt_rdata;
      end else begin
        s_next.rresp = relay_pkg::RESP_SLVERR;
      end
    end
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    // framing taken from nonvolatile copy once, right after reset
    if (!s_reg.cfg_loaded) begin
      s_next.cfg_loaded = 1'b1;
      s_next.cfg = nv_cfg_in;
      s_next.act_cfg = nv_cfg_in;
    end
    // self-test sequencing
    unique case (s_reg.st)
      relay_pkg::ST_TEST: begin
        s_next.test_cnt = s_reg.test_cnt + 28'h000_0001;
        if (!adc_ok || !dsp_ok) begin
          s_next.test_bad = 1'b1;
        end
        if (s_reg.test_cnt == 28'(TEST_CYC - 1)) begin
          s_next.st = relay_pkg::ST_RUN;
          if (s_reg.test_bad || !adc_ok || !dsp_ok) begin
            s_next.irf = 1'b1;
            s_next.irf_evt = !s_reg.irf;
          end
        end
      end
      relay_pkg::ST_RUN: begin
        if (fault) begin
          s_next.irf = 1'b1;
          s_next.irf_evt = !s_reg.irf;
        end
      end
    endcase
    // slow enables
    s_next.diag_cnt = diag_tick ? 28'h000_0000 : s_reg.diag_cnt + 28'h000_0001;
    s_next.scroll_cnt = scroll_tick ? 28'h000_0000 : s_reg.scroll_cnt + 28'h000_0001;
    if (s_reg.flash_cnt == 28'(FLASH_CYC - 1)) begin
      s_next.flash_cnt = 28'h000_0000;
      s_next.blink = !s_reg.blink;
    end else begin
      s_next.flash_cnt = s_reg.flash_cnt + 28'h000_0001;
    end
    // bit rate from the active framing only
    if (s_reg.baud_cnt == (s_reg.act_cfg[relay_pkg::CFG_BAUD] ?
                           14'(BAUD_FAST_CYC - 1) : 14'(BAUD_SLOW_CYC - 1))) begin
      s_next.baud_cnt = 14'h0000;
      s_next.bit_tick = 1'b1;
    end else begin
      s_next.baud_cnt = s_reg.baud_cnt + 14'h0001;
    end
    // a 5-bit node code keeps within the 31-slave span
    s_next.frame_accept = rx_addr_valid &&
                          rx_addr == {3'h0, s_reg.act_cfg[4:0]};
    // trip latch and caption: a new trip wins over the reset key
    s_next.trip_latch = any_trip || (s_reg.trip_latch && !reset_key);
    s_next.show_last = any_trip || (s_reg.show_last && !reset_key);
    if (any_trip) begin
      s_next.cause = CAUSE_OF(trip_vec, ext_trip);
    end
    // lamps
    s_next.lamp_open = !breaker_position_input;
    s_next.lamp_closed = bf_active ? s_reg.blink : breaker_position_input;
    s_next.lamp_trip = s_reg.trip_latch || ((|timing_vec) && s_reg.blink);
    s_next.lamp_pwr = s_reg.irf ? s_reg.blink : 1'b1;
    s_next.irf_out = s_reg.irf && s_reg.ctrl[relay_pkg::CTRL_IRF_TRIP];
    // display scroll and pause
    if (reset_key) begin
      s_next.paused = !s_reg.paused;
    end
    if (!s_reg.paused && scroll_tick) begin
      s_next.idx = (s_reg.idx == 3'(relay_pkg::NUM_MEAS - 1)) ? 3'h0 : s_reg.idx + 3'h1;
    end else if (s_reg.paused && up_key) begin
      s_next.idx = (s_reg.idx == 3'(relay_pkg::NUM_MEAS - 1)) ? 3'h0 : s_reg.idx + 3'h1;
    end else if (s_reg.paused && down_key) begin
      s_next.idx = (s_reg.idx == 3'h0) ? 3'(relay_pkg::NUM_MEAS - 1) : s_reg.idx - 3'h1;
    end
    // snapshot taken when the instant view is entered
    s_next.freeze_q = s_reg.ctrl[relay_pkg::CTRL_FREEZE];
    if (s_reg.ctrl[relay_pkg::CTRL_FREEZE] && !s_reg.freeze_q) begin
      s_next.snap = meas_in;
    end
    s_next.disp_val = s_reg.freeze_q ? s_reg.snap[s_reg.idx] : meas_in[s_reg.idx];
  end

  // priority encoder of the cause: lowest element first, then external, internal fault last
  function automatic logic [3:0] CAUSE_OF(input logic [6:0] tv, input logic ext);
    logic [3:0] c;
    c = ext ? relay_pkg::CAUSE_EXT : relay_pkg::CAUSE_IRF;
    for (int i = 6; i >= 0; i--) begin
      if (tv[i]) begin
        c = 4'(i + 1);
      end
    end
    return c;
  endfunction : CAUSE_OF

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.st <= relay_pkg::ST_TEST;
      s_reg.ctrl <= relay_pkg::CTRL_RST;
      s_reg.cfg <= relay_pkg::CFG_RST;
      s_reg.act_cfg <= relay_pkg::CFG_RST;
      s_reg.lamp_pwr <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
  assign s_axi_wready = !s_reg.w_got && !s_reg.bvalid;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = !s_reg.rd_pend && !s_reg.rvalid;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign nv_cfg_out = s_reg.cfg;
  assign nv_write = s_reg.nv_wr;
  assign irf_trip_out = s_reg.irf_out;
  assign irf_event = s_reg.irf_evt;
  assign lamp_open = s_reg.lamp_open;
  assign lamp_closed = s_reg.lamp_closed;
  assign lamp_trip = s_reg.lamp_trip;
  assign power_fault_lamp = s_reg.lamp_pwr;
  assign last_trip_caption = s_reg.show_last;
  assign cause_code = s_reg.cause;
  assign cause_blink = s_reg.show_last && s_reg.blink;
  assign disp_index = s_reg.idx;
  assign disp_value = s_reg.disp_val;
  assign node_address = s_reg.act_cfg[4:0];
  assign parity_mode = s_reg.act_cfg[6:5];
  assign baud_fast = s_reg.act_cfg[relay_pkg::CFG_BAUD];
  assign proto_iec = s_reg.act_cfg[relay_pkg::CFG_PROTO];
  assign bit_tick = s_reg.bit_tick;
  assign frame_accept = s_reg.frame_accept;

  // checks
  open_lamp_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !sys_rst && !breaker_position_input |=> lamp_open) else $error("open lamp not lit");
  closed_lamp_a: assert property (@(posedge mclk) disable iff (sys_rst)
    breaker_position_input && !bf_active |=> lamp_closed) else $error("closed lamp not lit");
  bf_flash_a: assert property (@(posedge mclk) disable iff (sys_rst)
    bf_active |=> lamp_closed == $past(s_reg.blink)) else $error("closed lamp not flashing");
  trip_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (|trip_vec) ##1 !reset_key |=> lamp_trip) else $error("trip lamp not latched");
  power_lamp_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !s_reg.irf ##1 !s_reg.irf |-> power_fault_lamp) else $error("power lamp dark");
  notrip_fault_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !s_reg.ctrl[0] |=> !irf_trip_out) else $error("outputs driven in no-trip mode");
  trip_fault_a: assert property (@(posedge mclk) disable iff (sys_rst)
    s_reg.irf && s_reg.ctrl[0] |=> irf_trip_out) else $error("fault trip not driven");
  cfg_frozen_a: assert property (@(posedge mclk) disable iff (sys_rst)
    s_reg.cfg_loaded |=> $stable(s_reg.act_cfg)) else $error("framing changed live");
  node_match_a: assert property (@(posedge mclk) disable iff (sys_rst)
    frame_accept |-> $past(rx_addr) == {3'h0, node_address}) else $error("foreign address");
  store_check_a: assert property (@(posedge mclk) disable iff (sys_rst)
    nv_write |-> s_reg.chk_pend) else $error("store without checksum");
endmodule : relay_status

//--- common/relay_pkg.sv
/*
  constants shared by the relay status block: register map, field positions,
  reset values, timing and state codes.
  assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package relay_pkg;
  localparam int CLK_HZ = 100_000_000;
  // times and bit rates in their own units
  localparam int FLASH_MS = 250;
  localparam int SCROLL_MS = 2000;
  localparam int DIAG_US = 1000;
  localparam int TEST_MS = 10;
  localparam int BAUD_SLOW = 9600;
  localparam int BAUD_FAST = 19200;
  // derived cycle counts
  localparam int FLASH_CYC = CLK_HZ / 1000 * FLASH_MS;
  localparam int SCROLL_CYC = CLK_HZ / 1000 * SCROLL_MS;
  localparam int DIAG_CYC = CLK_HZ / 1_000_000 * DIAG_US;
  localparam int TEST_CYC = CLK_HZ / 1000 * TEST_MS;
  localparam int BAUD_SLOW_CYC = CLK_HZ / BAUD_SLOW;
  localparam int BAUD_FAST_CYC = CLK_HZ / BAUD_FAST;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CFG_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] ACT_CFG_OFS = 8'h0C;
  localparam logic [7:0] DISP_OFS = 8'h10;
  localparam logic [7:0] CNT_OFS = 8'h40;
  // control fields
  localparam int CTRL_IRF_TRIP = 0;
  localparam int CTRL_FREEZE = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  // framing config fields
  localparam int CFG_NODE_LSB = 0;
  localparam int CFG_PAR_LSB = 5;
  localparam int CFG_BAUD = 7;
  localparam int CFG_PROTO = 8;
  localparam logic [8:0] CFG_RST = 9'h001;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam int NUM_CNT = 15;
  localparam int NUM_MEAS = 6;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // cause codes shown with the last-trip caption
  localparam logic [3:0] CAUSE_EXT = 4'h8;
  localparam logic [3:0] CAUSE_IRF = 4'h9;
  typedef enum logic [1:0] {ST_TEST = 2'b01, ST_RUN = 2'b10} state_t;
endpackage : relay_pkg

//--- design/counter_mem.sv
/*
  operation counters: one saturating 16-bit counter per event input,
  with a registered read port.
  assumes increment inputs are one-cycle pulses on mclk.
*/
`timescale 1ns/1ps
module counter_mem (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [relay_pkg::NUM_CNT-1:0] inc,
  input wire logic [3:0] raddr,
  output logic [15:0] rdata
);
  typedef struct packed {
    logic [relay_pkg::NUM_CNT-1:0][15:0] cnt;
    logic [15:0] rdata;
  } mem_t;
  mem_t s_reg, s_next;
  logic [relay_pkg::NUM_CNT-1:0][15:0] cnt_next;

  // per entry: count up, stick at the top instead of wrapping
  for (genvar i = 0; i < relay_pkg::NUM_CNT; i++) begin : g_cnt
    assign cnt_next[i] = (inc[i] && s_reg.cnt[i] != relay_pkg::CNT_MAX) ?
                         s_reg.cnt[i] + 16'h0001 : s_reg.cnt[i];
    sat_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
      s_reg.cnt[i] == relay_pkg::CNT_MAX |=> s_reg.cnt[i] == relay_pkg::CNT_MAX)
      else $error("counter wrapped past maximum");
  end

  // unmapped index reads zero
  always_comb begin
    s_next = s_reg;
    s_next.cnt = cnt_next;
    s_next.rdata = (raddr < 4'(relay_pkg::NUM_CNT)) ? s_reg.cnt[raddr] : 16'h0000;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;
endmodule : counter_mem

//--- tb/bus_master_model.sv
/*
  supervisory master model: offers address bytes to the slave receiver.
  assumes the caller steps it from the bench clock, one byte per call.
*/
`timescale 1ns/1ps
module bus_master_model (
  input wire logic mclk,
  output logic [7:0] rx_addr,
  output logic rx_addr_valid
);
  initial begin
    rx_addr = 8'h00;
    rx_addr_valid = 1'b0;
  end
  // one byte, then the line shows the inverse so a stale value never matches
  task automatic send(input logic [7:0] a);
    @(posedge mclk);
    rx_addr <= a;
    rx_addr_valid <= 1'b1;
    @(posedge mclk);
    rx_addr <= ~a;
    rx_addr_valid <= 1'b0;
  endtask : send
endmodule : bus_master_model

//--- tb/tb_relay_status.sv
/*
  self-checking bench for relay_status: bus access, lamps, framing,
  counters and internal fault handling.
  assumes the shortened timing parameters set at the instance below.
*/
`timescale 1ns/1ps
module tb_relay_status;
  localparam int FL = 8;
  logic mclk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, adc_ok, bkr, bf_active;
  logic reset_key, rx_addr_valid, frame_accept, lamp_open, lamp_closed;
  logic lamp_trip, pfl, cap, baud_fast, proto_iec, bit_tick, irf_trip_out;
  logic [7:0] awaddr, araddr, nv_sum, rx_addr, ctrl_sh;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, parity_mode;
  logic [8:0] nv_cfg_out, nv_cfg_in;
  logic [6:0] timing_vec;
  logic [14:0] ev;
  logic [3:0] cause_code;
  logic [4:0] node_address;
  logic [relay_pkg::NUM_MEAS-1:0][15:0] meas;
  logic ext_trip, up_key, down_key, nv_write, irf_event;
  logic [2:0] disp_index;
  logic [15:0] disp_value;
  int bad_count, total_checks, nv_writes, irf_events;
  // store model: checksum follows what was stored
  assign nv_sum = nv_cfg_out[7:0] + {7'h00, nv_cfg_out[8]} + ctrl_sh;

  relay_status #(.FLASH_CYC(FL), .SCROLL_CYC(16), .DIAG_CYC(8), .TEST_CYC(20),
    .BAUD_SLOW_CYC(20), .BAUD_FAST_CYC(10)) relay_status_i (
    .mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .adc_ok(adc_ok), .dsp_ok(1'b1), .nv_sum(nv_sum), .nv_cfg_in(nv_cfg_in),
    .nv_cfg_out(nv_cfg_out), .nv_write(nv_write), .breaker_position_input(bkr),
    .bf_active(bf_active), .bf_event(ev[7]), .timing_vec(timing_vec),
    .trip_vec(ev[6:0]), .ext_trip(ext_trip), .reclose_evt(ev[12:9]),
    .reclose_fail(ev[13]), .hw_recovery(ev[14]), .reset_key(reset_key),
    .up_key(up_key), .down_key(down_key), .meas_in(meas), .irf_trip_out(irf_trip_out),
    .irf_event(irf_event), .lamp_open(lamp_open), .lamp_closed(lamp_closed),
    .lamp_trip(lamp_trip), .power_fault_lamp(pfl), .last_trip_caption(cap),
    .cause_code(cause_code), .cause_blink(), .disp_index(disp_index),
    .disp_value(disp_value),
    .node_address(node_address), .parity_mode(parity_mode), .baud_fast(baud_fast),
    .proto_iec(proto_iec), .bit_tick(bit_tick), .rx_addr(rx_addr),
    .rx_addr_valid(rx_addr_valid), .frame_accept(frame_accept));

  bus_master_model bus_master_model_i (
    .mclk(mclk), .rx_addr(rx_addr), .rx_addr_valid(rx_addr_valid));

  // one-cycle pulses counted at the edge that samples them
  always @(posedge mclk) begin
    if (nv_write === 1'b1) nv_writes <= nv_writes + 1;
    if (irf_event === 1'b1) irf_events <= irf_events + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic results;
    $display("checks=%0d errors=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // settle point just after an edge, so registered outputs have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  // write: both halves offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    int n;
    n = 0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      #1;
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
    end while (((awvalid && !ta) || (wvalid && !tw)) && n < 50);
    do begin
      #1;
      tb = bvalid;
      r = bresp;
      @(posedge mclk);
      n++;
    end while (!tb && n < 100);
    bready <= 1'b0;
    chk(r, er);
  endtask : wr

  // read and compare masked data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] er);
    logic t;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      #1;
      t = arready;
      @(posedge mclk);
      n++;
    end while (!t && n < 50);
    arvalid <= 1'b0;
    do begin
      #1;
      t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      n++;
    end while (!t && n < 100);
    rready <= 1'b0;
    chk(d & m, e);
    chk(r, er);
  endtask : rd

  // lamp seen both lit and dark over two flash periods means flashing
  task automatic flashes(input int sel, input logic exp);
    logic s0, s1, v;
    s0 = 1'b0;
    s1 = 1'b0;
    repeat (2 * FL + 4) begin
      cyc(1);
      v = (sel == 0) ? lamp_closed : (sel == 1) ? lamp_trip : pfl;
      if (v === 1'b0) s0 = 1'b1;
      if (v === 1'b1) s1 = 1'b1;
    end
    chk(s0 && s1, exp);
  endtask : flashes

  task automatic s_frame;
    int n;
    chk(node_address, 5'h05);
    chk(parity_mode, relay_pkg::PAR_ODD);
    chk(baud_fast, 1'b1);
    chk(proto_iec, 1'b0);
    n = 0;
    while (bit_tick !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (bit_tick !== 1'b1 && n < 40);
    chk(n, 10);
  endtask : s_frame

  task automatic s_addr(input logic [7:0] a, input logic exp);
    logic seen;
    seen = 1'b0;
    bus_master_model_i.send(a);
    // the accept pulse stands for one cycle from the edge send returns on
    repeat (4) begin
      #1;
      if (frame_accept === 1'b1) seen = 1'b1;
      @(posedge mclk);
    end
    chk(seen, exp);
  endtask : s_addr

  task automatic s_breaker;
    bkr <= 1'b1;
    cyc(2);
    chk({lamp_closed, lamp_open}, 2'b10);
    @(posedge mclk);
    bkr <= 1'b0;
    cyc(2);
    chk({lamp_closed, lamp_open}, 2'b01);
    @(posedge mclk);
    bkr <= 1'b1;
    bf_active <= 1'b1;
    flashes(0, 1'b1);
    @(posedge mclk);
    bf_active <= 1'b0;
  endtask : s_breaker

  // each event input once; trips also set the latch and cause
  task automatic s_count;
    @(posedge mclk);
    timing_vec <= 7'h04;
    flashes(1, 1'b1);
    timing_vec <= 7'h00;
    for (int i = 0; i < 15; i++) begin
      if (i == 8) continue;
      @(posedge mclk);
      ev <= 15'h0001 << i;
      @(posedge mclk);
      ev <= 15'h0000;
      cyc(2);
      if (i < 7) chk({cap, cause_code}, {1'b1, 4'(i + 1)});
      rd(8'(relay_pkg::CNT_OFS + 4 * i), 32'hFFFF, 32'h1, relay_pkg::RESP_OK);
    end
    @(posedge mclk);
    ext_trip <= 1'b1;
    @(posedge mclk);
    ext_trip <= 1'b0;
    cyc(2);
    chk({cap, cause_code}, {1'b1, relay_pkg::CAUSE_EXT});
    flashes(1, 1'b0);
    chk(lamp_trip, 1'b1);
    @(posedge mclk);
    reset_key <= 1'b1;
    @(posedge mclk);
    reset_key <= 1'b0;
    cyc(2);
    chk({lamp_trip, cap}, 2'b00);
  endtask : s_count

  // paused display: keys step the index, instant view holds a snapshot
  task automatic s_view;
    logic [2:0] i0;
    logic [15:0] e;
    i0 = disp_index;
    @(posedge mclk);
    up_key <= 1'b1;
    @(posedge mclk);
    up_key <= 1'b0;
    cyc(2);
    chk(disp_index, (i0 == 3'(relay_pkg::NUM_MEAS - 1)) ? 3'h0 : i0 + 3'h1);
    @(posedge mclk);
    down_key <= 1'b1;
    @(posedge mclk);
    down_key <= 1'b0;
    cyc(2);
    chk(disp_index, i0);
    for (int k = 0; k < relay_pkg::NUM_MEAS; k++) begin
      meas[k] <= 16'(16'h1111 * (k + 1));
    end
    e = 16'(16'h1111 * (i0 + 1));
    cyc(2);
    chk(disp_value, e);
    ctrl_sh = 8'h02;
    wr(relay_pkg::CTRL_OFS, 32'h0000_0002, relay_pkg::RESP_OK);
    meas <= '0;
    cyc(2);
    chk(disp_value, e);
  endtask : s_view

  task automatic s_cfg;
    wr(relay_pkg::CFG_OFS, 32'h0000_0146, relay_pkg::RESP_OK);
    chk(nv_cfg_out, 9'h146);
    chk(node_address, 5'h05);
    rd(relay_pkg::ACT_CFG_OFS, 32'h0000_01FF, 32'h0000_00A5, relay_pkg::RESP_OK);
    chk(nv_writes, 1);
    rd(8'h80, 32'hFFFF_FFFF, 32'h0000_0000, relay_pkg::RESP_SLVERR);
    wr(8'h84, 32'h0000_0001, relay_pkg::RESP_SLVERR);
  endtask : s_cfg

  task automatic s_fault;
    int n;
    ctrl_sh = 8'h01;
    wr(relay_pkg::CTRL_OFS, 32'h0000_0001, relay_pkg::RESP_OK);
    @(posedge mclk);
    adc_ok <= 1'b0;
    n = 0;
    while (irf_trip_out !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    chk(irf_trip_out, 1'b1);
    chk(cause_code, relay_pkg::CAUSE_IRF);
    flashes(2, 1'b1);
    rd(8'(relay_pkg::CNT_OFS + 32), 32'hFFFF, 32'h1, relay_pkg::RESP_OK);
    chk(irf_events, 1);
  endtask : s_fault

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    results();
  end

  initial begin
    {sys_rst, adc_ok} = 2'b11;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {bkr, bf_active, reset_key, timing_vec, ev} = '0;
    {ext_trip, up_key, down_key} = 3'h0;
    {awaddr, araddr, wdata, ctrl_sh} = '0;
    nv_cfg_in = 9'h0A5;
    meas = '0;
    cyc(6);
    chk({pfl, lamp_trip}, 2'b10);
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    cyc(2);
    s_frame();
    cyc(24);
    rd(relay_pkg::STATUS_OFS, 32'h0000_0002, 32'h0000_0002, relay_pkg::RESP_OK);
    flashes(2, 1'b0);
    chk(pfl, 1'b1);
    s_addr(8'h05, 1'b1);
    s_addr(8'h06, 1'b0);
    s_breaker();
    s_count();
    s_view();
    s_cfg();
    s_fault();
    results();
  end
endmodule : tb_relay_status
